// File: core/fps_filter.sv
// blanking filter: output rises only after input holds high for len cycles, falls at the first low sample
`timescale 1ns/1ps
`default_nettype none
module fps_filter #(
    parameter int unsigned LEN = 16
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic in_i,
    output logic      hit_o
);
    logic [31:0] cnt_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !in_i) begin
            cnt_q <= 32'h0;
            hit_o <= 1'b0;
        end else if (cnt_q >= LEN - 1) begin
            hit_o <= 1'b1; // R22
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule : fps_filter
`default_nettype wire

// File: core/fps_pkg.sv
// package of constants and types for the flyback pwm sequencer
// Notes on behaviour
// [R1] start-up source turns on with line present, off at supply start level.
// [R2] first arrival at start level only refills; switching begins at the next.
// [R3] refill below refill level unless line is absent or thermal trip.
// [R4] reduced start-up current while supply is below the short level.
// [R5] supply stop level turns controller off and clears the overload timer.
// [R6] nominal switching frequency is a build option, 65 or 100 kHz.
// [R7] gate drive forced low once on-time reaches 80 percent of period.
// [R8] triangle jitter of about six percent at 125 Hz, also in foldback.
// [R9] peak comparator ignored for 250 ns after turn-on, then ends pulse.
// [R10] limit comparator caps peak setpoint at maximum sense level.
// [R11] soft-start ramps setpoint from zero in fifteen equal steps.
// [R12] during soft-start the first of the two comparators ends the pulse.
// [R13] soft-start ignores low latch threshold and doubles latch bias current.
// [R14] winding short level stops switching at once and enters protection.
// [R15] overload timer runs while setpoint sits on the clamp; expiry protects.
// [R16] auto-recovery restarts after retry wait; latched waits for supply reset.
// [R17] latch input high or low threshold latches off until supply reset.
// [R18] skip: stop pulses below skip entry, resume above skip exit.
// [R19] foldback lowers frequency progressively down to lowest frequency.
// [R20] overload timer not started when max duty ended the pulse.
// [R21] foldback disabled while running at maximum duty.
// [R22] latch input spikes shorter than filter windows are blanked.
// [R23] all comparator results pass two flip-flops before use.
package fps_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned CLK_NS          = 25;
    localparam int unsigned FSW_NOM_65_HZ   = 65_000;
    localparam int unsigned FSW_NOM_100_HZ  = 100_000;
    localparam int unsigned FSW_MIN_HZ      = 27_000;
    localparam int unsigned MAX_DUTY_PCT    = 80;
    localparam int unsigned JITTER_PCT      = 6;
    localparam int unsigned JITTER_HZ       = 125;
    localparam int unsigned BLANK_NS        = 250;
    localparam int unsigned BLANK_CYC       = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SS_STEPS        = 15;
    localparam int unsigned SS_TIME_US      = 4000;
    localparam int unsigned SS_STEP_CYC     =
        (SS_TIME_US * (CLK_HZ / 1_000_000)) / SS_STEPS;
    localparam int unsigned FAULT_TIME_US   = 128_000;
    localparam int unsigned FAULT_CYC       =
        FAULT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RETRY_TIME_US   = 1_000_000;
    localparam int unsigned RETRY_CYC       =
        RETRY_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LATCH_HI_US     = 50;
    localparam int unsigned LATCH_HI_CYC    =
        LATCH_HI_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LATCH_LO_US     = 350;
    localparam int unsigned LATCH_LO_CYC    =
        LATCH_LO_US * (CLK_HZ / 1_000_000);
    localparam int unsigned FOLD_STEPS      = 16;
    localparam logic [3:0]  SS_LEVEL_RST    = 4'h0;

    // comparator results from the analog front end
    typedef struct packed {
        logic line_present;   // line_sense_input above line_present_level
        logic sup_start;      // supply at or above start level
        logic sup_refill;     // supply at or below refill level
        logic sup_short;      // supply below short level
        logic sup_stop;       // supply at or below stop level
        logic peak_trip;      // sense ramp above regulation_input / 5
        logic limit_trip;     // sense ramp above peak_limit_setpoint
        logic ss_trip;        // sense ramp above soft-start staircase
        logic short_trip;     // sense at winding_short_level
        logic skip_below;     // regulation_input below skip_entry_level
        logic skip_above;     // regulation_input above skip_exit_level
        logic fold_below;     // regulation_input below foldback_entry_level
        logic latch_hi;       // latch input above high threshold
        logic latch_lo;       // latch input below low threshold
        logic thermal_trip;
    } fps_cmp_t;

    typedef enum logic [2:0] {
        FPS_OFF     = 3'b000,
        FPS_CHARGE1 = 3'b001,
        FPS_REFILL  = 3'b010,
        FPS_RUN     = 3'b011,
        FPS_PROT    = 3'b100,
        FPS_RETRY   = 3'b101,
        FPS_LATCHED = 3'b110
    } fps_state_t;
endpackage : fps_pkg

// File: core/fps_seq.sv
// flyback pwm sequencer: start-up, oscillator, pwm, soft-start, protection
`timescale 1ns/1ps
`default_nettype none
module fps_seq
    import fps_pkg::*;
#(
    parameter int unsigned FSW_HZ    = fps_pkg::FSW_NOM_65_HZ,
    parameter bit          AUTO_REC  = 1'b0,
    parameter int unsigned FAULT_N   = fps_pkg::FAULT_CYC,
    parameter int unsigned RETRY_N   = fps_pkg::RETRY_CYC,
    parameter int unsigned SS_STEP_N = fps_pkg::SS_STEP_CYC,
    parameter int unsigned LHI_N     = fps_pkg::LATCH_HI_CYC,
    parameter int unsigned LLO_N     = fps_pkg::LATCH_LO_CYC
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire fps_pkg::fps_cmp_t cmp_i,
    output logic                  gate_drive_out_o,
    output logic                  startup_src_on_o,
    output logic                  startup_src_low_o,
    output logic                  latch_bias_dbl_o,
    output logic [3:0]            ss_level_o,
    output logic                  skip_active_o,
    output logic                  fault_o,
    output logic                  latched_off_o
);
    import fps_pkg::*;

    localparam int unsigned PER_NOM = CLK_HZ / FSW_HZ;
    localparam int unsigned PER_MAX = CLK_HZ / FSW_MIN_HZ;
    localparam int unsigned JIT_DEV = PER_NOM * JITTER_PCT / 100;
    localparam int unsigned JIT_HALF = CLK_HZ / (2 * JITTER_HZ);
    localparam int unsigned JIT_STEP_N = JIT_HALF / (2 * JIT_DEV + 1);
    localparam int unsigned FOLD_INC = (PER_MAX - PER_NOM) / FOLD_STEPS;
    localparam int unsigned FOLD_DWELL = 4;

    fps_cmp_t   c;
    fps_state_t st_q;
    logic       lhi_f;
    logic       llo_f;

    fps_sync #(.W($bits(fps_cmp_t))) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (cmp_i),
        .sync_o    (c)
    ); // R23

    fps_filter #(.LEN(LHI_N)) u_fhi (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .in_i      (c.latch_hi),
        .hit_o     (lhi_f)
    ); // R22

    fps_filter #(.LEN(LLO_N)) u_flo (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .in_i      (c.latch_lo),
        .hit_o     (llo_f)
    ); // R22

    // ---- start-up current source
    logic src_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            src_q <= 1'b0;
        end else if (c.thermal_trip || !c.line_present) begin
            src_q <= 1'b0; // R3
        end else if (c.sup_start) begin
            src_q <= 1'b0; // R1
        end else if (st_q == FPS_OFF || c.sup_refill) begin
            src_q <= 1'b1; // R1 R3
        end
    end
    assign startup_src_on_o  = src_q;
    assign startup_src_low_o = c.sup_short; // R4

    // ---- soft-start staircase
    logic [3:0]  ss_q;
    logic [31:0] ss_cnt_q;
    logic        in_ss;
    assign in_ss = (st_q == FPS_RUN) && (ss_q < 4'(SS_STEPS));
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || st_q != FPS_RUN) begin
            ss_q     <= SS_LEVEL_RST; // R11
            ss_cnt_q <= 32'h0;
        end else if (in_ss) begin
            if (ss_cnt_q >= SS_STEP_N - 1) begin
                ss_cnt_q <= 32'h0;
                ss_q     <= ss_q + 4'h1; // R11
            end else begin
                ss_cnt_q <= ss_cnt_q + 32'h1;
            end
        end
    end
    assign ss_level_o       = ss_q;
    assign latch_bias_dbl_o = in_ss; // R13

    // ---- skip mode with hysteresis
    logic skip_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            skip_q <= 1'b0;
        end else if (c.skip_below) begin
            skip_q <= 1'b1; // R18
        end else if (c.skip_above) begin
            skip_q <= 1'b0; // R18
        end
    end
    assign skip_active_o = skip_q;

    // ---- jitter: triangle offset on period
    logic [15:0] jit_q;
    logic        jit_up_q;
    logic [31:0] jit_cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            jit_q     <= 16'h0;
            jit_up_q  <= 1'b1;
            jit_cnt_q <= 32'h0;
        end else if (jit_cnt_q >= JIT_STEP_N - 1) begin
            jit_cnt_q <= 32'h0;
            if (jit_up_q) begin
                if (jit_q >= 16'(2 * JIT_DEV)) jit_up_q <= 1'b0;
                else jit_q <= jit_q + 16'h1; // R8
            end else begin
                if (jit_q == 16'h0) jit_up_q <= 1'b1;
                else jit_q <= jit_q - 16'h1; // R8
            end
        end else begin
            jit_cnt_q <= jit_cnt_q + 32'h1;
        end
    end

    // ---- frequency foldback: extra period added step by step
    logic [4:0]  fold_q;
    logic [3:0]  fold_dw_q;
    logic        at_max_duty_q;
    logic        cyc_end;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fold_q    <= 5'h0;
            fold_dw_q <= 4'h0;
        end else if (cyc_end) begin
            if (fold_dw_q >= 4'(FOLD_DWELL - 1)) begin
                fold_dw_q <= 4'h0;
                if (c.fold_below && !at_max_duty_q
                    && fold_q < 5'(FOLD_STEPS))
                    fold_q <= fold_q + 5'h1; // R19 R21
                else if ((!c.fold_below || at_max_duty_q) && fold_q != 5'h0)
                    fold_q <= fold_q - 5'h1; // R21
            end else begin
                fold_dw_q <= fold_dw_q + 4'h1;
            end
        end
    end

    // ---- oscillator and pwm
    logic [15:0] per;
    logic [15:0] ton_max;
    logic [15:0] ph_q;
    logic        drv_q;
    logic        run_ok;
    logic        end_peak;
    logic        latch_hit;
    logic        flt_exp;
    assign per = 16'(PER_NOM - JIT_DEV) + jit_q
               + 16'(FOLD_INC) * {11'h0, fold_q}; // R6 R8 R19
    assign ton_max = 16'((32'(per) * MAX_DUTY_PCT) / 100); // R7
    assign cyc_end = (ph_q >= per - 16'h1);
    // gate drops at the same edge that the state leaves run
    assign run_ok  = (st_q == FPS_RUN) && !skip_q && !c.short_trip
                   && !latch_hit && !flt_exp
                   && !c.sup_stop && !c.thermal_trip;
    // peak end after blanking; soft-start and feedback comparators are or'ed
    assign end_peak = (ph_q >= 16'(BLANK_CYC)) // R9
        && (c.peak_trip || c.limit_trip        // R9 R10
            || (in_ss && c.ss_trip));          // R12

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ph_q <= 16'h0;
        end else if (cyc_end) begin
            ph_q <= 16'h0;
        end else begin
            ph_q <= ph_q + 16'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            drv_q         <= 1'b0;
            at_max_duty_q <= 1'b0;
        end else if (!run_ok) begin
            drv_q <= 1'b0; // R14 R15 R17 R18
        end else if (cyc_end) begin
            drv_q <= 1'b1;
        end else if (drv_q && ph_q >= ton_max - 16'h1) begin
            drv_q         <= 1'b0; // R7
            at_max_duty_q <= 1'b1;
        end else if (drv_q && end_peak) begin
            drv_q         <= 1'b0; // R9
            at_max_duty_q <= 1'b0;
        end
    end
    assign gate_drive_out_o = drv_q;

    // ---- overload timer
    logic [31:0] flt_cnt_q;
    logic        ovl_q;
    logic        flt_run;
    // setpoint on the clamp: last pulse was ended by the limit comparator
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || st_q != FPS_RUN) begin
            ovl_q <= 1'b0;
        end else if (drv_q && ph_q >= ton_max - 16'h1) begin
            ovl_q <= 1'b0; // R20
        end else if (drv_q && end_peak) begin
            ovl_q <= c.limit_trip; // R15
        end
    end
    assign flt_run = (st_q == FPS_RUN) && !in_ss && ovl_q; // R15 R20
    assign flt_exp = flt_cnt_q >= FAULT_N - 1;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || c.sup_stop || !flt_run) begin
            flt_cnt_q <= 32'h0; // R5 R15
        end else if (!flt_exp) begin
            flt_cnt_q <= flt_cnt_q + 32'h1; // R15
        end
    end

    // ---- controller state
    logic [31:0] rty_cnt_q;
    assign latch_hit = lhi_f || (llo_f && !in_ss); // R13 R17
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_q      <= FPS_OFF;
            rty_cnt_q <= 32'h0;
        end else if (c.sup_stop) begin
            st_q <= FPS_OFF; // R5
        end else if (c.thermal_trip && st_q != FPS_LATCHED) begin
            st_q <= FPS_OFF;
        end else begin
            unique case (st_q)
                FPS_OFF:
                    if (c.sup_start) st_q <= FPS_CHARGE1; // R2
                FPS_CHARGE1:
                    if (c.sup_refill) st_q <= FPS_REFILL; // R2
                FPS_REFILL:
                    if (c.sup_start) st_q <= FPS_RUN; // R2
                FPS_RUN:
                    if (latch_hit) st_q <= FPS_LATCHED; // R17
                    else if (c.short_trip || flt_exp) begin
                        st_q <= AUTO_REC ? FPS_RETRY : FPS_LATCHED; // R14 R16
                        rty_cnt_q <= 32'h0;
                    end
                FPS_RETRY:
                    if (latch_hit) st_q <= FPS_LATCHED;
                    else if (rty_cnt_q >= RETRY_N - 1) st_q <= FPS_REFILL; // R16
                    else rty_cnt_q <= rty_cnt_q + 32'h1;
                FPS_LATCHED:
                    st_q <= FPS_LATCHED; // R16 R17
                default:
                    st_q <= FPS_OFF;
            endcase
        end
    end
    assign fault_o       = (st_q == FPS_RETRY) || (st_q == FPS_LATCHED);
    assign latched_off_o = (st_q == FPS_LATCHED);
endmodule : fps_seq
`default_nettype wire

// File: core/fps_sync.sv
// two flip-flop synchroniser for a bus of comparator levels
`timescale 1ns/1ps
`default_nettype none
module fps_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i; // R23
            sync_o <= meta_q;  // R23
        end
    end
endmodule : fps_sync
`default_nettype wire

// File: tb/fps_seq_chk.sv
// assertion checker for the flyback pwm sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fps_seq_chk
    import fps_pkg::*;
#(
    parameter int unsigned FSW_HZ = fps_pkg::FSW_NOM_65_HZ
) (
    input wire logic              sys_clk_i,
    input wire logic              rst_i,
    input wire fps_pkg::fps_cmp_t cmp_i,
    input wire logic              gate_drive_out_o,
    input wire logic              startup_src_on_o,
    input wire logic              startup_src_low_o,
    input wire logic              latch_bias_dbl_o,
    input wire logic [3:0]        ss_level_o,
    input wire logic              skip_active_o,
    input wire logic              fault_o,
    input wire logic              latched_off_o
);
    localparam int MAX_ON = (CLK_HZ / FSW_HZ) * 106 / 100 * 80 / 100 + 2;
    logic [11:0] on_cnt_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !gate_drive_out_o) begin
            on_cnt_q <= 12'h000;
        end else begin
            on_cnt_q <= on_cnt_q + 12'h001;
        end
    end
    sequence s_turn_on;
        $rose(gate_drive_out_o);
    endsequence
    sequence s_abort;
        ##[0:8] (cmp_i.short_trip || cmp_i.sup_stop || cmp_i.thermal_trip
                 || cmp_i.latch_hi || cmp_i.latch_lo || cmp_i.skip_below
                 || fault_o);
    endsequence
    sequence s_refill_need;
        (cmp_i.line_present && cmp_i.sup_refill && !cmp_i.sup_start
         && !cmp_i.thermal_trip) [*4];
    endsequence
    chk_duty_on_max: assert property (int'(on_cnt_q) <= MAX_ON)
        else $error("gate high beyond max duty");
    chk_blank_hold: assert property (s_turn_on |->
        gate_drive_out_o [*8] or s_abort) else $error("pulse cut in blanking");
    chk_ss_staircase: assert property (ss_level_o != $past(ss_level_o) |->
        ss_level_o == $past(ss_level_o) + 4'h1 || ss_level_o == 4'h0)
        else $error("soft-start step not by one");
    chk_low_current: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
        startup_src_low_o == $past(cmp_i.sup_short, 2))
        else $error("reduced current select wrong");
    chk_src_off_start: assert property (cmp_i.sup_start [*4] |->
        !startup_src_on_o) else $error("source on at start level");
    chk_src_refill: assert property (s_refill_need |-> startup_src_on_o)
        else $error("source off at refill level");
    chk_stop_clears: assert property (cmp_i.sup_stop [*5] |->
        !gate_drive_out_o && !fault_o && !latched_off_o)
        else $error("stop level did not turn off");
    chk_latch_hold: assert property (latched_off_o && !cmp_i.sup_stop
        && !$past(cmp_i.sup_stop) && !$past(cmp_i.sup_stop, 2) |=>
        latched_off_o) else $error("latch released without reset");
    chk_latch_quiet: assert property (latched_off_o |->
        !gate_drive_out_o && fault_o) else $error("latched but driving");
    chk_skip_no_gate: assert property (skip_active_o && $past(skip_active_o)
        |-> !gate_drive_out_o) else $error("pulse during skip");
    chk_short_stop: assert property (cmp_i.short_trip && gate_drive_out_o
        |-> ##[1:4] !gate_drive_out_o) else $error("short did not stop gate");
endmodule : fps_seq_chk
bind fps_seq fps_seq_chk #(.FSW_HZ(FSW_HZ)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmp_i(cmp_i),
    .gate_drive_out_o(gate_drive_out_o), .startup_src_on_o(startup_src_on_o),
    .startup_src_low_o(startup_src_low_o), .latch_bias_dbl_o(latch_bias_dbl_o),
    .ss_level_o(ss_level_o), .skip_active_o(skip_active_o),
    .fault_o(fault_o), .latched_off_o(latched_off_o));
`default_nettype wire

// File: tb/fps_seq_tb_top.sv
// self-checking bench for the flyback pwm sequencer
`timescale 1ns/1ps
`default_nettype none
module fps_seq_tb_top;
    import fps_pkg::*;
    typedef struct packed {
        logic line, start, refill, short_lvl, src, low, run;
    } fps_row_t;
    localparam int PER = CLK_HZ / FSW_NOM_65_HZ;
    localparam int FLT = 200;
    localparam fps_row_t ROWS [6] = '{7'h0a, 7'h4e, 7'h44, 7'h60, 7'h54, 7'h61};
    localparam int FB [3] = '{40, 3, 1000};
    localparam int LO [3] = '{40, 10, 460};
    localparam int HI [3] = '{48, 14, 522};
    logic       sys_clk_i, rst_i, pk, lm, st;
    logic       gate_drive_out_o, startup_src_on_o, startup_src_low_o;
    logic       latch_bias_dbl_o, skip_active_o, fault_o, latched_off_o;
    logic [3:0] ss_level_o;
    logic [9:0] fb_set, lim_set;
    fps_cmp_t   drv_cmp, cmp_w;
    int         n_fail, n_compared;
    always_comb begin
        cmp_w = drv_cmp;
        cmp_w.peak_trip = pk;
        cmp_w.limit_trip = lm;
        cmp_w.ss_trip = st;
    end
    fps_seq #(.FSW_HZ(FSW_NOM_65_HZ), .AUTO_REC(1'b0), .FAULT_N(FLT),
        .RETRY_N(300), .SS_STEP_N(20), .LHI_N(8), .LLO_N(16)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmp_i(cmp_w),
        .gate_drive_out_o(gate_drive_out_o), .startup_src_on_o(startup_src_on_o),
        .startup_src_low_o(startup_src_low_o), .latch_bias_dbl_o(latch_bias_dbl_o),
        .ss_level_o(ss_level_o), .skip_active_o(skip_active_o),
        .fault_o(fault_o), .latched_off_o(latched_off_o));
    fps_stage u_stage (.sys_clk_i(sys_clk_i), .gate_i(gate_drive_out_o),
        .fb_set_i(fb_set), .lim_set_i(lim_set), .ss_level_i(ss_level_o),
        .peak_trip_o(pk), .limit_trip_o(lm), .ss_trip_o(st));
    task complete_run();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask : tick
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task rng(input string nm, input int v, input int lo, input int hi);
        chk(nm, {15'h0, (v >= lo && v <= hi)}, 16'h0001);
    endtask : rng
    task watch(input int n, output logic hi, output int wmax, output int wmin);
        int w;
        bit arm;
        hi = 1'b0;
        wmax = 0;
        wmin = 9999;
        w = 0;
        arm = 1'b0;
        repeat (n) begin
            tick(1);
            if (gate_drive_out_o === 1'b1) begin
                hi = 1'b1;
                if (arm) w++;
            end else begin
                arm = 1'b1;
                if (w > 0 && w > wmax) wmax = w;
                if (w > 0 && w < wmin) wmin = w;
                w = 0;
            end
        end
    endtask : watch
    task wait_on(input bit ss, input int lim, output int n);
        n = 0;
        while (ss ? ss_level_o !== 4'hf : fault_o !== 1'b1) begin
            tick(1);
            n++;
            if (n >= lim) begin
                n_fail++;
                complete_run();
            end
        end
    endtask : wait_on
    task apply_row(input int i, input int n);
        logic hi;
        int   wx, wn;
        drv_cmp.line_present = ROWS[i].line;
        drv_cmp.sup_start = ROWS[i].start;
        drv_cmp.sup_refill = ROWS[i].refill;
        drv_cmp.sup_short = ROWS[i].short_lvl;
        drv_cmp.sup_stop = 1'b0;
        tick(8);
        chk("src_on", {15'h0, startup_src_on_o}, {15'h0, ROWS[i].src});
        chk("src_low", {15'h0, startup_src_low_o}, {15'h0, ROWS[i].low});
        if (n > 0) begin
            watch(n, hi, wx, wn);
            chk("running", {15'h0, hi}, {15'h0, ROWS[i].run});
        end
    endtask : apply_row
    task bring_up();
        apply_row(3, 0);
        apply_row(4, 0);
        apply_row(5, 0);
    endtask : bring_up
    task stop_supply();
        drv_cmp.sup_start = 1'b0;
        drv_cmp.sup_refill = 1'b1;
        drv_cmp.sup_stop = 1'b1;
        tick(8);
        chk("stop_out", {13'h0, gate_drive_out_o, fault_o, latched_off_o},
            16'h0000);
        bring_up();
    endtask : stop_supply
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin : main
        logic hi;
        int   wx, wn, n;
        n_fail = 0;
        n_compared = 0;
        rst_i = 1'b1;
        drv_cmp = '0;
        fb_set = 10'h3e8;
        lim_set = 10'h3e8;
        tick(3);
        chk("reset_out", {8'h0, gate_drive_out_o, startup_src_on_o, fault_o,
            latched_off_o, ss_level_o}, 16'h0000);
        rst_i = 1'b0;
        for (int i = 0; i < 6; i++) apply_row(i, PER + 100);
        stop_supply();
        chk("bias_dbl", {15'h0, latch_bias_dbl_o}, 16'h0001);
        drv_cmp.latch_lo = 1'b1;
        tick(24);
        chk("ss_latch_lo", {15'h0, latched_off_o}, 16'h0000);
        drv_cmp.latch_lo = 1'b0;
        wait_on(1'b1, 2000, n);
        chk("ss_top", {12'h0, ss_level_o}, 16'h000f);
        for (int k = 0; k < 3; k++) begin
            fb_set = 10'(FB[k]);
            watch(PER, hi, wx, wn);
            watch(2 * PER + 100, hi, wx, wn);
            rng("width_max", wx, LO[k], HI[k]);
            rng("width_min", wn, LO[k], HI[k]);
        end
        drv_cmp.fold_below = 1'b1;
        watch(6 * PER, hi, wx, wn);
        rng("fold_max_duty", wx, LO[2], HI[2]);
        drv_cmp.fold_below = 1'b0;
        drv_cmp.skip_below = 1'b1;
        tick(6);
        chk("skip_on", {15'h0, skip_active_o}, 16'h0001);
        watch(PER + 50, hi, wx, wn);
        chk("skip_gate", {15'h0, hi}, 16'h0000);
        drv_cmp.skip_below = 1'b0;
        drv_cmp.skip_above = 1'b1;
        watch(PER + 100, hi, wx, wn);
        chk("skip_exit", {15'h0, hi}, 16'h0001);
        drv_cmp.latch_hi = 1'b1;
        tick(4);
        drv_cmp.latch_hi = 1'b0;
        tick(10);
        chk("spike_hi", {15'h0, latched_off_o}, 16'h0000);
        drv_cmp.latch_hi = 1'b1;
        tick(16);
        drv_cmp.latch_hi = 1'b0;
        tick(4);
        chk("latch_hi", {15'h0, latched_off_o}, 16'h0001);
        rst_i = 1'b1;
        tick(3);
        rst_i = 1'b0;
        tick(2);
        chk("latch_rst", {15'h0, latched_off_o}, 16'h0000);
        bring_up();
        drv_cmp.short_trip = 1'b1;
        wait_on(1'b0, 200, n);
        chk("short_latch", {15'h0, latched_off_o}, 16'h0001);
        drv_cmp.short_trip = 1'b0;
        stop_supply();
        wait_on(1'b1, 2000, n);
        lim_set = 10'h03c;
        wait_on(1'b0, 60000, n);
        rng("fault_delay", n, FLT, 60000);
        chk("ovl_latch", {15'h0, latched_off_o}, 16'h0001);
        complete_run();
    end
endmodule : fps_seq_tb_top
`default_nettype wire

// File: tb/fps_stage.sv
// behavioural power stage: sense ramp and its comparators
`timescale 1ns/1ps
`default_nettype none
module fps_stage (
    input  wire logic       sys_clk_i,
    input  wire logic       gate_i,
    input  wire logic [9:0] fb_set_i,
    input  wire logic [9:0] lim_set_i,
    input  wire logic [3:0] ss_level_i,
    output logic            peak_trip_o,
    output logic            limit_trip_o,
    output logic            ss_trip_o
);
    logic [9:0]  ramp_q;
    logic [13:0] ss_ref;
    always_ff @(posedge sys_clk_i) begin
        if (!gate_i) begin
            ramp_q <= 10'h000;
        end else if (ramp_q != 10'h3ff) begin
            ramp_q <= ramp_q + 10'h001;
        end
    end
    assign ss_ref       = 14'(ss_level_i) * 14'(lim_set_i) / 14'h00f;
    assign peak_trip_o  = gate_i && (ramp_q >= fb_set_i);
    assign limit_trip_o = gate_i && (ramp_q >= lim_set_i);
    assign ss_trip_o    = gate_i && (14'(ramp_q) >= ss_ref);
endmodule : fps_stage
`default_nettype wire
